// *** verilog/bcr_backlight_regs.v ***
// Backlight configuration register group and the logic it steers.
// Assumes the serial-bus slave logic presents one-cycle register write and
// read strobes on the system clock; the dimming pin arrives asynchronously.
`timescale 1ns/1ns
`include "bcr_map_regs.vh"

// Operation
// - Limit-select bit one picks lower boost limit.
// - Frequency field selects eight internal dimming frequencies.
// - Spread-off bit one stops spread modulation.
// - Amount bit: zero six percent, one three.
// - Threshold code zero off, else 3/6/8 V.
// - Pump-off bit one stops series gate pump.
// - Clearing pump-off while running shuts pump and backlight down.
// - Backlight-off bit keeps backlight section disabled.
// - String two to six bits disable sinks.
// - Fade bit enables gradual duty changes.
// - Gain bit: one 12.5, zero 6.25 percent.
// - Fade updates every 2^N dimming cycles, N capped at 5.
// - Code zero updates every dimming cycle.
// - Eight-bit scratch register without functional effect.
// - Pin-select zero uses on-time duty, one pin.
module bcr_backlight_regs #(
   parameter DUTY_W = 12,
   parameter CNT_W = 20,
   parameter PER0 = `BCR_CLK_HZ / `BCR_FPWM0_HZ,
   parameter PER1 = `BCR_CLK_HZ / `BCR_FPWM1_HZ,
   parameter PER2 = `BCR_CLK_HZ / `BCR_FPWM2_HZ,
   parameter PER3 = `BCR_CLK_HZ / `BCR_FPWM3_HZ,
   parameter PER4 = `BCR_CLK_HZ / `BCR_FPWM4_HZ,
   parameter PER5 = `BCR_CLK_HZ / `BCR_FPWM5_HZ,
   parameter PER6 = `BCR_CLK_HZ / `BCR_FPWM6_HZ,
   parameter PER7 = `BCR_CLK_HZ / `BCR_FPWM7_HZ
) (
   // Clock and reset
   input wire CLK_SYS_IN,
   input wire RST_B_IN,
   // Register access from the serial-bus slave
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire REG_WR_IN,
   input wire REG_RD_IN,
   output wire [7:0] REG_RDATA_OUT,
   output wire REG_RVALID_OUT,
   output wire REG_HIT_OUT,
   // Device state and dimming sources
   input wire GLOBAL_ON_IN,
   input wire DIM_PIN_SEL_IN,
   input wire [DUTY_W-1:0] ON_TIME_IN,
   input wire DIM_PIN_IN,
   // Boost and spread controls
   output wire BOOST_LOW_LIMIT_OUT,
   output wire [CNT_W-1:0] DIM_PERIOD_OUT,
   output wire DIM_CYCLE_OUT,
   output wire SPREAD_EN_OUT,
   output wire SPREAD_WIDE_OUT,
   // Diagnostics thresholds
   output wire SHORT_DET_EN_OUT,
   output wire [7:0] SHORT_THR_DV_OUT,
   // Gate pump and shutdown
   output wire GATE_PUMP_EN_OUT,
   output wire SHUTDOWN_OUT,
   // Backlight drive
   output wire BACKLIGHT_EN_OUT,
   output wire [5:0] LED_SINK_EN_OUT,
   output wire PWM_OUT,
   output wire [DUTY_W-1:0] FADE_DUTY_OUT
);

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   reg [7:0] boost_limit_spread_config_q;
   reg [7:0] string_disable_ctrl_q;
   reg [7:0] fade_ctrl_q;
   reg [7:0] user_scratch_1_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   reg rvalid_q;
   reg hit;

   // Field views.
   wire boost_low_limit_sel = boost_limit_spread_config_q[`BCR_BIT_BOOST_LOW];
   wire [2:0] freq_sel =
      boost_limit_spread_config_q[`BCR_FLD_FREQ_HI:`BCR_FLD_FREQ_LO];
   wire spread_off = boost_limit_spread_config_q[`BCR_BIT_SPREAD_OFF];
   wire spread_amount_sel = boost_limit_spread_config_q[`BCR_BIT_SPREAD_AMT];
   wire [1:0] short_sel =
      boost_limit_spread_config_q[`BCR_FLD_SHORT_HI:`BCR_FLD_SHORT_LO];
   wire gate_pump_off = string_disable_ctrl_q[`BCR_BIT_PUMP_OFF];
   wire backlight_off = string_disable_ctrl_q[`BCR_BIT_BL_OFF];
   wire [4:0] string_off = string_disable_ctrl_q[`BCR_FLD_STR_HI:`BCR_FLD_STR_LO];
   wire fade_gain_hi = fade_ctrl_q[`BCR_BIT_FADE_GAIN];
   wire fade_en = fade_ctrl_q[`BCR_BIT_FADE_EN];
   wire [2:0] fade_exponent = fade_ctrl_q[`BCR_FLD_EXP_HI:`BCR_FLD_EXP_LO];

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------

   // Stores host writes; the new value steers the logic from the next edge.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         boost_limit_spread_config_q <= `BCR_RST_BOOST_SPREAD;
         string_disable_ctrl_q <= `BCR_RST_STRING_DIS;
         fade_ctrl_q <= `BCR_RST_FADE;
         user_scratch_1_q <= `BCR_RST_SCRATCH;
      end else if (REG_WR_IN) begin
         case (REG_ADDR_IN)
            `BCR_OFF_BOOST_SPREAD: begin
               boost_limit_spread_config_q <= REG_WDATA_IN;
            end
            `BCR_OFF_STRING_DIS: begin
               string_disable_ctrl_q <= REG_WDATA_IN & `BCR_MASK_STRING_DIS;
            end
            `BCR_OFF_FADE: begin
               fade_ctrl_q <= REG_WDATA_IN & `BCR_MASK_FADE;
            end
            `BCR_OFF_SCRATCH: begin
               user_scratch_1_q <= REG_WDATA_IN;
            end
            default: begin
               user_scratch_1_q <= user_scratch_1_q;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------

   // Address decode; reserved bits were masked on write and read as zero.
   always @* begin
      hit = 1'b1;
      rdata_d = 8'h00;
      case (REG_ADDR_IN)
         `BCR_OFF_BOOST_SPREAD: begin
            rdata_d = boost_limit_spread_config_q;
         end
         `BCR_OFF_STRING_DIS: begin
            rdata_d = string_disable_ctrl_q;
         end
         `BCR_OFF_FADE: begin
            rdata_d = fade_ctrl_q;
         end
         `BCR_OFF_SCRATCH: begin
            rdata_d = user_scratch_1_q;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   // Read data is captured one edge after the read strobe.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= REG_RD_IN;
         if (REG_RD_IN) begin
            rdata_q <= rdata_d;
         end
      end
   end

   assign REG_RDATA_OUT = rdata_q;
   assign REG_RVALID_OUT = rvalid_q;
   assign REG_HIT_OUT = hit;

   // ----------------------------------------------------------------
   // Dimming pin synchroniser
   // ----------------------------------------------------------------
   reg dim_meta_q;
   reg dim_sync_q;

   // Two flops before any logic looks at the asynchronous pin.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         dim_meta_q <= 1'b0;
         dim_sync_q <= 1'b0;
      end else begin
         dim_meta_q <= DIM_PIN_IN;
         dim_sync_q <= dim_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Gate pump and shutdown
   // ----------------------------------------------------------------
   reg pump_off_prev_q;
   reg shutdown_q;
   wire shutdown_set = GLOBAL_ON_IN && pump_off_prev_q && !gate_pump_off;

   // A pump-off falling edge while on latches shutdown until global off.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pump_off_prev_q <= 1'b0;
         shutdown_q <= 1'b0;
      end else begin
         pump_off_prev_q <= gate_pump_off;
         if (shutdown_set) begin
            shutdown_q <= 1'b1;
         end else if (!GLOBAL_ON_IN) begin
            shutdown_q <= 1'b0;
         end
      end
   end

   // Backlight section runs only when on, not disabled and not shut down.
   wire bl_run = GLOBAL_ON_IN && !backlight_off && !shutdown_q && !shutdown_set;

   // ----------------------------------------------------------------
   // Dimming period generator
   // ----------------------------------------------------------------
   reg [CNT_W-1:0] period;
   reg [CNT_W-1:0] cnt_q;
   reg tick_q;

   // Period in system clocks for the selected internal frequency.
   always @* begin
      case (freq_sel)
         3'h0: period = PER0[CNT_W-1:0];
         3'h1: period = PER1[CNT_W-1:0];
         3'h2: period = PER2[CNT_W-1:0];
         3'h3: period = PER3[CNT_W-1:0];
         3'h4: period = PER4[CNT_W-1:0];
         3'h5: period = PER5[CNT_W-1:0];
         3'h6: period = PER6[CNT_W-1:0];
         default: period = PER7[CNT_W-1:0];
      endcase
   end

   // Free-running cycle counter; a shorter new period wraps at once.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         cnt_q <= {CNT_W{1'b0}};
         tick_q <= 1'b0;
      end else if (cnt_q >= period - {{(CNT_W-1){1'b0}}, 1'b1}) begin
         cnt_q <= {CNT_W{1'b0}};
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Fade engine and duty compare
   // ----------------------------------------------------------------
   wire [DUTY_W-1:0] fade_duty;
   wire [CNT_W+DUTY_W-1:0] on_prod;
   wire [CNT_W-1:0] on_cnt;

   // Duty walks toward the on-time value once per fade interval.
   bcr_fade #(
      .DUTY_W(DUTY_W)
   ) u_fade (
      .clk_in(CLK_SYS_IN),
      .rst_b_in(RST_B_IN),
      .tick_in(tick_q),
      .fade_en_in(fade_en),
      .gain_hi_in(fade_gain_hi),
      .exp_in(fade_exponent),
      .target_in(ON_TIME_IN),
      .duty_out(fade_duty)
   );

   // On time in clocks is period times duty as a binary fraction.
   assign on_prod = period * fade_duty;
   assign on_cnt = on_prod[CNT_W+DUTY_W-1:DUTY_W];

   // Internal duty comes from the fade engine, else the synchronised pin.
   wire pwm_src = DIM_PIN_SEL_IN ? dim_sync_q : (cnt_q < on_cnt);

   // ----------------------------------------------------------------
   // Threshold decode
   // ----------------------------------------------------------------
   reg [7:0] short_dv;

   // Shorted-LED threshold in tenths of a volt; code zero disables.
   always @* begin
      case (short_sel)
         2'h1: short_dv = `BCR_SHORT_DV_1;
         2'h2: short_dv = `BCR_SHORT_DV_2;
         2'h3: short_dv = `BCR_SHORT_DV_3;
         default: short_dv = `BCR_SHORT_DV_OFF;
      endcase
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   reg boost_low_q;
   reg [CNT_W-1:0] period_q;
   reg spread_en_q;
   reg spread_wide_q;
   reg short_en_q;
   reg [7:0] short_dv_q;
   reg pump_en_q;
   reg bl_en_q;
   reg [5:0] sink_en_q;
   reg pwm_q;

   // All analog-facing controls leave the block from flops.
   always @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         boost_low_q <= 1'b0;
         period_q <= {CNT_W{1'b0}};
         spread_en_q <= 1'b0;
         spread_wide_q <= 1'b0;
         short_en_q <= 1'b0;
         short_dv_q <= `BCR_SHORT_DV_OFF;
         pump_en_q <= 1'b0;
         bl_en_q <= 1'b0;
         sink_en_q <= 6'h00;
         pwm_q <= 1'b0;
      end else begin
         boost_low_q <= boost_low_limit_sel;
         period_q <= period;
         spread_en_q <= !spread_off;
         spread_wide_q <= !spread_off && !spread_amount_sel;
         short_en_q <= (short_sel != `BCR_SHORT_OFF);
         short_dv_q <= short_dv;
         pump_en_q <= !gate_pump_off && !shutdown_q && !shutdown_set;
         bl_en_q <= bl_run;
         sink_en_q <= {6{bl_run}} & {~string_off, 1'b1};
         pwm_q <= bl_run && pwm_src;
      end
   end

   assign BOOST_LOW_LIMIT_OUT = boost_low_q;
   assign DIM_PERIOD_OUT = period_q;
   assign DIM_CYCLE_OUT = tick_q;
   assign SPREAD_EN_OUT = spread_en_q;
   assign SPREAD_WIDE_OUT = spread_wide_q;
   assign SHORT_DET_EN_OUT = short_en_q;
   assign SHORT_THR_DV_OUT = short_dv_q;
   assign GATE_PUMP_EN_OUT = pump_en_q;
   assign SHUTDOWN_OUT = shutdown_q;
   assign BACKLIGHT_EN_OUT = bl_en_q;
   assign LED_SINK_EN_OUT = sink_en_q;
   assign PWM_OUT = pwm_q;
   assign FADE_DUTY_OUT = fade_duty;

endmodule // bcr_backlight_regs

// *** verilog/bcr_map_regs.vh ***
// Constants for the backlight configuration register group.
// Assumes inclusion by bare name from the design files of this block.
`ifndef BCR_MAP_REGS_VH
`define BCR_MAP_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BCR_OFF_BOOST_SPREAD 8'h0c
`define BCR_OFF_STRING_DIS 8'h0d
`define BCR_OFF_FADE 8'h0e
`define BCR_OFF_SCRATCH 8'h0f

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BCR_RST_BOOST_SPREAD 8'h90
`define BCR_RST_STRING_DIS 8'h00
`define BCR_RST_FADE 8'h00
`define BCR_RST_SCRATCH 8'h00

// ----------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------
`define BCR_BIT_BOOST_LOW 7
`define BCR_FLD_FREQ_HI 6
`define BCR_FLD_FREQ_LO 4
`define BCR_BIT_SPREAD_OFF 3
`define BCR_BIT_SPREAD_AMT 2
`define BCR_FLD_SHORT_HI 1
`define BCR_FLD_SHORT_LO 0
`define BCR_BIT_PUMP_OFF 7
`define BCR_BIT_BL_OFF 5
`define BCR_FLD_STR_HI 4
`define BCR_FLD_STR_LO 0
`define BCR_BIT_FADE_GAIN 4
`define BCR_BIT_FADE_EN 3
`define BCR_FLD_EXP_HI 2
`define BCR_FLD_EXP_LO 0
`define BCR_MASK_STRING_DIS 8'hbf
`define BCR_MASK_FADE 8'h1f

// ----------------------------------------------------------------
// Dimming frequencies in Hz and the system clock rate
// ----------------------------------------------------------------
`define BCR_CLK_HZ 100000000
`define BCR_FPWM0_HZ 153
`define BCR_FPWM1_HZ 203
`define BCR_FPWM2_HZ 305
`define BCR_FPWM3_HZ 610
`define BCR_FPWM4_HZ 980
`define BCR_FPWM5_HZ 1220
`define BCR_FPWM6_HZ 1401
`define BCR_FPWM7_HZ 1634

// ----------------------------------------------------------------
// Shorted-LED thresholds in tenths of a volt
// ----------------------------------------------------------------
`define BCR_SHORT_OFF 2'h0
`define BCR_SHORT_DV_OFF 8'h00
`define BCR_SHORT_DV_1 8'h1e
`define BCR_SHORT_DV_2 8'h3c
`define BCR_SHORT_DV_3 8'h50

// ----------------------------------------------------------------
// Fade constants
// ----------------------------------------------------------------
`define BCR_FADE_EXP_MAX 3'h5
`define BCR_FADE_SHIFT_HI 3
`define BCR_FADE_SHIFT_LO 4

`endif

// *** verilog/bcr_fade.v ***
// Fade engine: walks the applied dimming duty toward its target.
// Assumes a one-cycle dimming tick from the same clock domain.
`timescale 1ns/1ns
`include "bcr_map_regs.vh"

module bcr_fade #(
   parameter DUTY_W = 12
) (
   // Clock and reset
   input wire clk_in,
   input wire rst_b_in,
   // Control
   input wire tick_in,
   input wire fade_en_in,
   input wire gain_hi_in,
   input wire [2:0] exp_in,
   input wire [DUTY_W-1:0] target_in,
   // Result
   output wire [DUTY_W-1:0] duty_out
);

   reg [DUTY_W-1:0] cur_q;
   reg [DUTY_W-1:0] cur_d;
   reg [5:0] ivl_q;
   reg [5:0] ivl_d;
   reg [2:0] exp_eff;
   reg [5:0] ivl_last;
   reg [DUTY_W-1:0] diff;
   reg [DUTY_W-1:0] step;

   // Next duty: a step of diff/8 or diff/16, at least one, every 2^N ticks, N capped at 5.
   always @* begin
      cur_d = cur_q;
      ivl_d = ivl_q;
      exp_eff = (exp_in > `BCR_FADE_EXP_MAX) ? `BCR_FADE_EXP_MAX : exp_in;
      ivl_last = (6'h01 << exp_eff) - 6'h01;
      diff = (target_in > cur_q) ? (target_in - cur_q) : (cur_q - target_in);
      step = gain_hi_in ? (diff >> `BCR_FADE_SHIFT_HI) : (diff >> `BCR_FADE_SHIFT_LO);
      if (step == {DUTY_W{1'b0}}) begin
         step = {{(DUTY_W-1){1'b0}}, 1'b1};
      end
      if (!fade_en_in) begin
         cur_d = target_in;
         ivl_d = 6'h00;
      end else if (tick_in) begin
         if (ivl_q >= ivl_last) begin
            ivl_d = 6'h00;
            if (target_in > cur_q) begin
               cur_d = cur_q + step;
            end else if (target_in < cur_q) begin
               cur_d = cur_q - step;
            end
         end else begin
            ivl_d = ivl_q + 6'h01;
         end
      end
   end

   // Applied duty and interval counter.
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cur_q <= {DUTY_W{1'b0}};
         ivl_q <= 6'h00;
      end else begin
         cur_q <= cur_d;
         ivl_q <= ivl_d;
      end
   end

   assign duty_out = cur_q;

endmodule // bcr_fade

// *** dv/bcr_asserts.sv ***
// Port checker for the backlight register group.
// Assumes it is bound onto bcr_backlight_regs and sees only its ports.
`timescale 1ns/1ns
// --------------------
// Checker
// --------------------
module bcr_asserts (
   // Clock and reset
   input wire CLK_SYS_IN,
   input wire RST_B_IN,
   // Register port
   input wire [7:0] REG_ADDR_IN,
   input wire [7:0] REG_WDATA_IN,
   input wire REG_WR_IN,
   input wire REG_RD_IN,
   input wire [7:0] REG_RDATA_OUT,
   input wire REG_RVALID_OUT,
   input wire REG_HIT_OUT,
   // Controls
   input wire GLOBAL_ON_IN,
   input wire BOOST_LOW_LIMIT_OUT,
   input wire DIM_CYCLE_OUT,
   input wire SPREAD_EN_OUT,
   input wire SPREAD_WIDE_OUT,
   input wire SHORT_DET_EN_OUT,
   input wire [7:0] SHORT_THR_DV_OUT,
   input wire GATE_PUMP_EN_OUT,
   input wire SHUTDOWN_OUT,
   input wire BACKLIGHT_EN_OUT,
   input wire [5:0] LED_SINK_EN_OUT
);
   // All checks use the system clock and are off during reset.
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   // Read answers come one cycle after the strobe and then hold.
   AST_RVALID: assert property (REG_RVALID_OUT == $past(REG_RD_IN))
      else $error("read valid misplaced");
   AST_RDHOLD: assert property (!REG_RVALID_OUT |-> $stable(REG_RDATA_OUT))
      else $error("read data moved without a read");
   AST_UNMAP: assert property (REG_RD_IN && !REG_HIT_OUT |=> REG_RDATA_OUT == 8'h00)
      else $error("unmapped read not zero");
   // Written boost and spread bits reach the controls two edges later.
   AST_BOOST: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0c
      |-> ##2 BOOST_LOW_LIMIT_OUT == $past(REG_WDATA_IN[7], 2))
      else $error("boost limit does not follow write");
   AST_SPREAD: assert property (REG_WR_IN && REG_ADDR_IN == 8'h0c
      |-> ##2 SPREAD_EN_OUT != $past(REG_WDATA_IN[3], 2))
      else $error("spread enable does not follow write");
   AST_WIDE: assert property (SPREAD_WIDE_OUT |-> SPREAD_EN_OUT)
      else $error("wide spread while spreading off");
   AST_SHORT: assert property ((SHORT_THR_DV_OUT == 8'h00) != SHORT_DET_EN_OUT)
      else $error("short check enable and threshold disagree");
   AST_PUMP: assert property (GATE_PUMP_EN_OUT |-> !SHUTDOWN_OUT)
      else $error("gate pump runs in shutdown");
   AST_BLOFF: assert property (!GLOBAL_ON_IN |=> !BACKLIGHT_EN_OUT && LED_SINK_EN_OUT == 6'h00)
      else $error("backlight on without enable");
   AST_CYC: assert property (DIM_CYCLE_OUT |=> !DIM_CYCLE_OUT)
      else $error("dimming tick longer than one cycle");
endmodule // bcr_asserts
bind bcr_backlight_regs bcr_asserts u_chk (.CLK_SYS_IN(CLK_SYS_IN), .RST_B_IN(RST_B_IN),
   .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
   .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT),
   .REG_HIT_OUT(REG_HIT_OUT), .GLOBAL_ON_IN(GLOBAL_ON_IN),
   .BOOST_LOW_LIMIT_OUT(BOOST_LOW_LIMIT_OUT), .DIM_CYCLE_OUT(DIM_CYCLE_OUT),
   .SPREAD_EN_OUT(SPREAD_EN_OUT), .SPREAD_WIDE_OUT(SPREAD_WIDE_OUT),
   .SHORT_DET_EN_OUT(SHORT_DET_EN_OUT), .SHORT_THR_DV_OUT(SHORT_THR_DV_OUT),
   .GATE_PUMP_EN_OUT(GATE_PUMP_EN_OUT), .SHUTDOWN_OUT(SHUTDOWN_OUT),
   .BACKLIGHT_EN_OUT(BACKLIGHT_EN_OUT), .LED_SINK_EN_OUT(LED_SINK_EN_OUT));

// *** dv/bcr_host.sv ***
// Host model driving the register strobes and the global enable.
// Assumes the design samples on the rising edge; this drives on falling.
`timescale 1ns/1ns
// --------------------
// Host model
// --------------------
module bcr_host (
   // Clock
   input wire clk_in,
   // Register port
   output reg [7:0] addr_out,
   output reg [7:0] wdata_out,
   output reg wr_out,
   output reg rd_out,
   input wire [7:0] rdata_in,
   input wire rvalid_in,
   // Device enable
   output reg on_out
);
   // Idle bus at time zero.
   initial begin
      {addr_out, wdata_out, wr_out, rd_out, on_out} = 19'h0;
   end
   // One write; released lines are inverted so stale values never pass.
   task wr(input [7:0] a, input [7:0] d);
      begin
         @(negedge clk_in);
         {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
         @(negedge clk_in);
         {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
      end
   endtask
   // One read; data is taken while the valid pulse stands.
   task rd(input [7:0] a, output [7:0] d, output v);
      begin
         @(negedge clk_in);
         {addr_out, rd_out} = {a, 1'b1};
         @(negedge clk_in);
         {d, v} = {rdata_in, rvalid_in};
         {addr_out, rd_out} = {~a, 1'b0};
      end
   endtask
   // Spreading is parked off while its amount changes.
   task spread_set(input [7:0] old, input [7:0] cfg);
      begin
         if (old[2] != cfg[2]) begin
            wr(8'h0c, old | 8'h08);
            wr(8'h0c, cfg | 8'h08);
         end
         wr(8'h0c, cfg);
      end
   endtask
   // String disables settle before the enable; no series switch is fitted.
   task up(input [7:0] dis);
      begin
         wr(8'h0d, dis | 8'h80);
         on_out = 1'b1;
      end
   endtask
   task down;
      begin
         @(negedge clk_in);
         on_out = 1'b0;
      end
   endtask
endmodule // bcr_host

// *** dv/tb.sv ***
// Self-checking bench for the backlight register group.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ns
`include "bcr_map_regs.vh"
// --------------------
// Bench top
// --------------------
module tb;
   reg clk;
   reg rst_b;
   reg sel;
   reg pin;
   reg [11:0] on_time;
   reg [11:0] exp_d;
   reg [7:0] mdl [0:3];
   reg [7:0] d;
   reg [7:0] rv8;
   reg [2:0] hist;
   reg rvf;
   wire [7:0] addr, wdat, rdat, thr;
   wire [19:0] per;
   wire [11:0] duty;
   wire [5:0] sink;
   wire wr_s, rd_s, rvld, hit, on, boost, cyc, sp_en, sp_w, det, pump, sd, bl, pwm;
   integer errors, tests_run, seed, i, j, n, k;
   // Design with shortened dimming periods.
   bcr_backlight_regs #(.PER0(20'h14), .PER1(20'h1e), .PER2(20'h28), .PER3(20'h32),
      .PER4(20'h3c)) DUT (
      .CLK_SYS_IN(clk), .RST_B_IN(rst_b), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdat),
      .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rvld),
      .REG_HIT_OUT(hit), .GLOBAL_ON_IN(on), .DIM_PIN_SEL_IN(sel), .ON_TIME_IN(on_time),
      .DIM_PIN_IN(pin), .BOOST_LOW_LIMIT_OUT(boost), .DIM_PERIOD_OUT(per),
      .DIM_CYCLE_OUT(cyc), .SPREAD_EN_OUT(sp_en), .SPREAD_WIDE_OUT(sp_w),
      .SHORT_DET_EN_OUT(det), .SHORT_THR_DV_OUT(thr), .GATE_PUMP_EN_OUT(pump),
      .SHUTDOWN_OUT(sd), .BACKLIGHT_EN_OUT(bl), .LED_SINK_EN_OUT(sink), .PWM_OUT(pwm),
      .FADE_DUTY_OUT(duty));
   bcr_host host (.clk_in(clk), .addr_out(addr), .wdata_out(wdat), .wr_out(wr_s),
      .rd_out(rd_s), .rdata_in(rdat), .rvalid_in(rvld), .on_out(on));
   // System clock, 10 ns period.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Expected decode of the dimming period and short threshold.
   function [19:0] per_of(input [2:0] c);
      per_of = c < 3'h5 ? 20'h14 + 20'ha * c : c == 3'h5 ? `BCR_CLK_HZ / `BCR_FPWM5_HZ :
         c == 3'h6 ? `BCR_CLK_HZ / `BCR_FPWM6_HZ : `BCR_CLK_HZ / `BCR_FPWM7_HZ;
   endfunction
   function [7:0] thr_of(input [1:0] c);
      thr_of = c == 2'h0 ? 8'h00 : c == 2'h1 ? 8'h1e : c == 2'h2 ? 8'h3c : 8'h50;
   endfunction
   // One fade step toward full scale.
   function [11:0] step(input [11:0] c, input g);
      reg [11:0] s;
      begin
         s = g ? (12'hfff - c) >> 3 : (12'hfff - c) >> 4;
         step = c + (s == 12'h000 ? 12'h001 : s);
      end
   endfunction
   // Comparison, verdict and bounded waits.
   task check(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks=%0d mismatches=%0d", tests_run, errors);
         if (errors == 0 && tests_run > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task wait_cyc;
      begin
         k = 0;
         while (cyc !== 1'b1) begin
            @(negedge clk);
            k = k + 1;
            if (k > 200) begin
               check(k, 0);
               report_and_stop;
            end
         end
         @(negedge clk);
      end
   endtask
   // Register access keeping the expected image in step.
   task wreg(input [7:0] a, input [7:0] x);
      begin
         host.wr(a, x);
         if (a[7:2] == 6'h03)
            mdl[a[1:0]] = x & (a == 8'h0d ? 8'hbf : a == 8'h0e ? 8'h1f : 8'hff);
      end
   endtask
   task rchk(input [7:0] a);
      begin
         host.rd(a, rv8, rvf);
         check(rvf, 1'b1);
         check(rv8, a[7:2] == 6'h03 ? mdl[a[1:0]] : 8'h00);
      end
   endtask
   task up(input [7:0] x);
      begin
         host.up(x);
         mdl[1] = (x | 8'h80) & 8'hbf;
      end
   endtask
   // Decoded controls two edges after the boost and spread byte changes.
   task dec(input [7:0] x);
      begin
         @(negedge clk);
         check(boost, x[7]);
         check(per, per_of(x[6:4]));
         check(sp_en, !x[3]);
         check(sp_w, !x[3] && !x[2]);
         check(thr, thr_of(x[1:0]));
         check(det, x[1:0] != 2'h0);
      end
   endtask
   task cfg(input [7:0] x);
      begin
         host.spread_set(mdl[0], x);
         mdl[0] = x;
         dec(x);
      end
   endtask
   task bl_chk;
      begin
         @(negedge clk);
         n = on && !mdl[1][5];
         check(bl, n);
         check(sink, n ? {~mdl[1][4:0], 1'b1} : 6'h00);
         check(pump, !mdl[1][7]);
      end
   endtask
   // Faded duty walks from zero toward full scale, sampled six cycles after each tick.
   task fade(input [2:0] e, input g);
      begin
         on_time = 12'h000;
         wreg(8'h0e, 8'h00);
         @(negedge clk);
         check(duty, 12'h000);
         wreg(8'h0e, {3'h0, g, 1'b1, e});
         {on_time, exp_d, n} = {12'hfff, 12'h000, 32'h0};
         for (j = 0; j < 8; j = j + 1) begin
            wait_cyc;
            repeat (5) @(negedge clk);
            if (duty !== exp_d) begin
               exp_d = step(exp_d, g);
               n = n + 1;
            end
            check(duty, exp_d);
         end
         check(n, 8 >> e);
      end
   endtask
   // High cycles over one whole period at a steady duty.
   task pwm_chk(input [11:0] t);
      begin
         on_time = t;
         wait_cyc;
         wait_cyc;
         n = 0;
         for (j = 0; j < per_of(mdl[0][6:4]); j = j + 1) begin
            @(negedge clk);
            n = n + pwm;
         end
         check(n, (per_of(mdl[0][6:4]) * t) >> 12);
      end
   endtask
   // Main sequence.
   initial begin
      {rst_b, sel, pin, on_time} = 15'h0;
      errors = 0;
      tests_run = 0;
      seed = 71138;
      {mdl[0], mdl[1], mdl[2], mdl[3]} = {`BCR_RST_BOOST_SPREAD, `BCR_RST_STRING_DIS,
         `BCR_RST_FADE, `BCR_RST_SCRATCH};
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      for (j = 12; j < 16; j = j + 1) rchk(j[7:0]);
      dec(mdl[0]);
      bl_chk;
      $display("reset test done");
      up(8'h00);
      bl_chk;
      wreg(8'h0d, 8'h00);
      repeat (3) @(negedge clk);
      check(sd, 1'b1);
      check(pump, 1'b0);
      check(bl, 1'b0);
      host.down;
      repeat (2) @(negedge clk);
      check(sd, 1'b0);
      $display("shutdown test done");
      for (i = 0; i < 8; i = i + 1) cfg({i[0], i[2:0], i[1], i[2], i[1:0]});
      for (i = 0; i < 24; i = i + 1) begin
         d = $random(seed);
         cfg(d);
         host.down;
         up(d);
         bl_chk;
         wreg(8'h0f, ~d);
         wreg(d | 8'h10, d);
         rchk(d | 8'h10);
         for (j = 12; j < 16; j = j + 1) rchk(j[7:0]);
      end
      $display("register test done");
      cfg(8'h20);
      fade(3'h0, 1'b0);
      fade(3'h1, 1'b1);
      fade(3'h2, 1'b1);
      $display("fade test done");
      wreg(8'h0e, 8'h00);
      host.down;
      up(8'h00);
      pwm_chk(12'h000);
      pwm_chk(12'hfff);
      pwm_chk($random(seed));
      sel = 1'b1;
      hist = 3'h0;
      for (i = 0; i < 40; i = i + 1) begin
         @(negedge clk);
         if (i > 4) check(pwm, hist[2]);
         pin = $random(seed);
         hist = {hist[1:0], pin};
      end
      $display("dimming test done");
      report_and_stop;
   end
endmodule // tb
